// file: common/prw_cfg.svh
`ifndef PRW_CFG_SVH
`define PRW_CFG_SVH

// Clock and tick base
`define PRW_CLK_MHZ       250
`define PRW_TICK_US       1
`define PRW_US_PER_MS     1000
`define PRW_TICK_CYC      (`PRW_CLK_MHZ * `PRW_TICK_US)

// Timing figures in their own units
`define PRW_STARTUP_MS    300
`define PRW_RUN_MS        13
`define PRW_RSTLOW_US     1100
`define PRW_OVF_US        1000

// Counter, register and bus widths
`define PRW_PRE_W         8
`define PRW_TMR_W         19
`define PRW_IVL_W         11
`define PRW_CNT_W         3
`define PRW_IRQ_W         3
`define PRW_ADDR_W        8
`define PRW_DATA_W        32

// Fault count at which the next fault latches reset low
`define PRW_FAULT_LAST    3'h3

// Register byte offsets
`define PRW_OFS_ENABLE    8'h00
`define PRW_OFS_FAULT     8'h04
`define PRW_OFS_STATUS    8'h08
`define PRW_OFS_IRQ_ST    8'h0C
`define PRW_OFS_IRQ_MSK   8'h10

// Field positions
`define PRW_BIT_MASK      0
`define PRW_BIT_LATCH     17
`define PRW_BIT_TO        0
`define PRW_BIT_OVF       1
`define PRW_BIT_DIS       0
`define PRW_BIT_PIN       1
`define PRW_BIT_CNT       4
`define PRW_BIT_STATE     8
`define PRW_IRQ_FAULT     0
`define PRW_IRQ_OVF       1
`define PRW_IRQ_LATCH     2

// Reset values
`define PRW_RST_MASK      1'h0
`define PRW_RST_FLAG      1'h0
`define PRW_RST_IRQ       3'h0
`define PRW_RST_CNT       3'h0
`define PRW_RST_OE_N      1'h1
`define PRW_RST_PIN_VAL   1'h0

`endif

// file: common/prw_pkg.sv
`include "prw_cfg.svh"
`default_nettype none

package prw_pkg;

  typedef logic [`PRW_PRE_W-1:0]  prw_pre_t;
  typedef logic [`PRW_TMR_W-1:0]  prw_tmr_t;
  typedef logic [`PRW_IVL_W-1:0]  prw_ivl_t;
  typedef logic [`PRW_CNT_W-1:0]  prw_cnt_t;
  typedef logic [`PRW_IRQ_W-1:0]  prw_irq_t;
  typedef logic [`PRW_DATA_W-1:0] prw_data_t;

  // One-hot watchdog states
  typedef enum logic [4:0]
  {
    PRW_ST_DISABLED = 5'h01,
    PRW_ST_STARTUP  = 5'h02,
    PRW_ST_RUN      = 5'h04,
    PRW_ST_RST_LOW  = 5'h08,
    PRW_ST_LATCHED  = 5'h10
  } prw_state_t;

  // Complete state of the watchdog
  typedef struct packed
  {
    prw_pre_t   prescale;
    prw_tmr_t   timer;
    prw_ivl_t   ivl;
    prw_state_t state;
    logic       pulse_prev;
    logic       dis_prev;
    logic       wake_prev;
    logic       mask;
    logic       latch_en;
    logic       strap_dflt;
    prw_cnt_t   flt_cnt;
    logic       to_flag;
    logic       ovf_flag;
    prw_irq_t   irq_st;
    prw_irq_t   irq_msk;
    prw_data_t  rdata;
    logic       irq;
    logic       rst_oe_n;
    logic       rst_val;
  } prw_regs_t;

endpackage : prw_pkg

`default_nettype wire

// file: core/prw_watchdog.sv
// The placing of the registers and strobed register access were left to the implementer.
`include "prw_cfg.svh"
`default_nettype none

module prw_watchdog
#(
  parameter int TICK_CYC      = `PRW_TICK_CYC,
  parameter int STARTUP_TICKS = `PRW_STARTUP_MS * `PRW_US_PER_MS / `PRW_TICK_US,
  parameter int RUN_TICKS     = `PRW_RUN_MS * `PRW_US_PER_MS / `PRW_TICK_US,
  parameter int RSTLOW_TICKS  = `PRW_RSTLOW_US / `PRW_TICK_US,
  parameter int OVF_TICKS     = `PRW_OVF_US / `PRW_TICK_US
)
(
  // Clock and power-on reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // Register port
  input  wire logic [`PRW_ADDR_W-1:0] addr,
  input  wire logic [`PRW_DATA_W-1:0] wr_data,
  input  wire logic                   wr_en,
  input  wire logic                   rd_en,
  output logic      [`PRW_DATA_W-1:0] rd_data,
  // Interrupt
  output logic                        irq,
  // Activity monitor and strap pins
  input  wire logic                   activity_pulse_input,
  input  wire logic                   watchdog_disable_pin,
  input  wire logic                   config_strap_pin,
  // Fault counter clear sources
  input  wire logic                   wake_pin,
  input  wire logic                   aux_regulator_three_uv,
  input  wire logic                   aux_regulator_four_uv,
  // Open-drain reset output
  input  wire logic                   primary_reset_output_in,
  output logic                        primary_reset_output_out,
  output logic                        primary_reset_output_oe_n
);

  //////////////////////////////////////////////////////////////////////////////

  // Limits cast once to the counter widths
  localparam prw_pkg::prw_pre_t PRE_LAST   = prw_pkg::prw_pre_t'(TICK_CYC - 1);
  localparam prw_pkg::prw_tmr_t TMR_START  = prw_pkg::prw_tmr_t'(STARTUP_TICKS);
  localparam prw_pkg::prw_tmr_t TMR_RUN    = prw_pkg::prw_tmr_t'(RUN_TICKS);
  localparam prw_pkg::prw_tmr_t TMR_RSTLOW = prw_pkg::prw_tmr_t'(RSTLOW_TICKS);
  localparam prw_pkg::prw_ivl_t IVL_OVF    = prw_pkg::prw_ivl_t'(OVF_TICKS);
  localparam prw_pkg::prw_ivl_t IVL_MAX    = '1;
  localparam prw_pkg::prw_pre_t PRE_ONE    = prw_pkg::prw_pre_t'(1);
  localparam prw_pkg::prw_tmr_t TMR_ONE    = prw_pkg::prw_tmr_t'(1);
  localparam prw_pkg::prw_ivl_t IVL_ONE    = prw_pkg::prw_ivl_t'(1);
  localparam prw_pkg::prw_cnt_t CNT_ONE    = prw_pkg::prw_cnt_t'(1);

  //////////////////////////////////////////////////////////////////////////////

  // Edge detectors shared by several pins
  function automatic logic edge_up(input logic cur, input logic prev);
    edge_up = cur & ~prev;
  endfunction : edge_up

  function automatic logic edge_dn(input logic cur, input logic prev);
    edge_dn = ~cur & prev;
  endfunction : edge_dn

  //////////////////////////////////////////////////////////////////////////////

  prw_pkg::prw_regs_t r;
  prw_pkg::prw_regs_t next_r;

  logic               tick;
  logic               pulse_rise;
  logic               too_fast;
  logic               good_edge;
  logic               dis_fall;
  logic               cnt_clear;
  logic               expired;
  logic               fault;
  logic               enter_latch;
  logic               fault_read;
  prw_pkg::prw_cnt_t  cnt_base;
  prw_pkg::prw_irq_t  events;

  //////////////////////////////////////////////////////////////////////////////

  // Event decode from pins and timers
  always_comb
  begin
    tick       = (r.prescale == PRE_LAST);
    pulse_rise = edge_up(activity_pulse_input, r.pulse_prev);
    too_fast   = pulse_rise && (r.ivl < IVL_OVF);
    good_edge  = pulse_rise && !too_fast;
    dis_fall   = edge_dn(watchdog_disable_pin, r.dis_prev);
    cnt_clear  = edge_up(wake_pin, r.wake_prev)
                 || aux_regulator_three_uv
                 || aux_regulator_four_uv;
    expired    = (r.timer == '0);
    fault_read = rd_en && (addr == `PRW_OFS_FAULT);
  end

  //////////////////////////////////////////////////////////////////////////////

  // Next state of the whole block
  always_comb
  begin
    next_r      = r;
    fault       = 1'b0;
    enter_latch = 1'b0;
    events      = '0;

    // Pin history for edge detection
    next_r.pulse_prev = activity_pulse_input;
    next_r.dis_prev   = watchdog_disable_pin;
    next_r.wake_prev  = wake_pin;

    // Microsecond tick, free running
    next_r.prescale = tick ? '0 : r.prescale + PRE_ONE;

    // Time since last rising edge, saturating so idle pulses never look fast
    if (pulse_rise)
      next_r.ivl = '0;
    else if (tick && (r.ivl != IVL_MAX))
      next_r.ivl = r.ivl + IVL_ONE;

    // Down-counting timeout, stops at zero
    if (tick && !expired)
      next_r.timer = r.timer - TMR_ONE;

    // Watchdog sequence
    case (r.state)
      prw_pkg::PRW_ST_DISABLED:
      begin
        if (dis_fall)
        begin
          next_r.state = prw_pkg::PRW_ST_STARTUP;
          next_r.timer = TMR_START;
        end
      end
      prw_pkg::PRW_ST_STARTUP:
      begin
        if (watchdog_disable_pin)
          next_r.state = prw_pkg::PRW_ST_DISABLED;
        else if (pulse_rise)
        begin
          next_r.state = prw_pkg::PRW_ST_RUN;
          next_r.timer = TMR_RUN;
        end
        else if (expired)
          fault = 1'b1;
      end
      prw_pkg::PRW_ST_RUN:
      begin
        if (watchdog_disable_pin)
          next_r.state = prw_pkg::PRW_ST_DISABLED;
        else if (good_edge)
          next_r.timer = TMR_RUN;
        else if (expired)
          fault = 1'b1;
      end
      prw_pkg::PRW_ST_RST_LOW:
      begin
        // A pulse already under way always runs to its end
        if (expired)
        begin
          next_r.timer = TMR_START;
          if (watchdog_disable_pin)
            next_r.state = prw_pkg::PRW_ST_DISABLED;
          else
            next_r.state = prw_pkg::PRW_ST_STARTUP;
        end
      end
      prw_pkg::PRW_ST_LATCHED:
      begin
        // Only a counter clear frees a latched reset
        if (cnt_clear)
        begin
          next_r.state = prw_pkg::PRW_ST_STARTUP;
          next_r.timer = TMR_START;
        end
      end
      default:
      begin
        next_r.state = prw_pkg::PRW_ST_STARTUP;
        next_r.timer = TMR_START;
      end
    endcase

    // Software write to the enable register
    if (wr_en && (addr == `PRW_OFS_ENABLE))
    begin
      next_r.mask     = wr_data[`PRW_BIT_MASK];
      next_r.latch_en = wr_data[`PRW_BIT_LATCH];
    end

    // Fault counter, clear applied before this cycle's fault counts
    cnt_base       = cnt_clear ? '0 : r.flt_cnt;
    next_r.flt_cnt = cnt_base;

    // Fault outcome; masked faults restart with no reset pulse for self-test
    if (fault)
    begin
      if (r.mask)
      begin
        next_r.state = prw_pkg::PRW_ST_STARTUP;
        next_r.timer = TMR_START;
      end
      else
      begin
        if (r.latch_en)
          next_r.flt_cnt = cnt_base + CNT_ONE;
        if (r.latch_en && (cnt_base == `PRW_FAULT_LAST))
        begin
          next_r.state = prw_pkg::PRW_ST_LATCHED;
          enter_latch  = 1'b1;
        end
        else
        begin
          next_r.state = prw_pkg::PRW_ST_RST_LOW;
          next_r.timer = TMR_RSTLOW;
        end
        // Device reset wipes the enable register settings back to defaults; the interrupt mask is kept
        next_r.mask     = `PRW_RST_MASK;
        next_r.latch_en = r.strap_dflt;
      end
    end

    // Fault flags clear on read, but a new event in that cycle wins
    if (fault_read)
    begin
      next_r.to_flag  = `PRW_RST_FLAG;
      next_r.ovf_flag = `PRW_RST_FLAG;
    end
    if (fault)
      next_r.to_flag = 1'b1;
    if (too_fast && (r.state == prw_pkg::PRW_ST_RUN))
      next_r.ovf_flag = 1'b1;

    // Interrupt status: write one to clear, set wins
    events[`PRW_IRQ_FAULT] = fault;
    events[`PRW_IRQ_OVF]   = too_fast && (r.state == prw_pkg::PRW_ST_RUN);
    events[`PRW_IRQ_LATCH] = enter_latch;
    for (int i = 0; i < `PRW_IRQ_W; i++)
    begin
      if (wr_en && (addr == `PRW_OFS_IRQ_ST) && wr_data[i])
        next_r.irq_st[i] = 1'b0;
      if (events[i])
        next_r.irq_st[i] = 1'b1;
    end
    if (wr_en && (addr == `PRW_OFS_IRQ_MSK))
      next_r.irq_msk = wr_data[`PRW_IRQ_W-1:0];
    next_r.irq = |(next_r.irq_st & next_r.irq_msk);

    // Read data stands only in the cycle after the strobe
    next_r.rdata = '0;
    if (rd_en)
    begin
      case (addr)
        `PRW_OFS_ENABLE:
        begin
          next_r.rdata[`PRW_BIT_MASK]  = r.mask;
          next_r.rdata[`PRW_BIT_LATCH] = r.latch_en;
        end
        `PRW_OFS_FAULT:
        begin
          next_r.rdata[`PRW_BIT_TO]  = r.to_flag;
          next_r.rdata[`PRW_BIT_OVF] = r.ovf_flag;
        end
        `PRW_OFS_STATUS:
        begin
          next_r.rdata[`PRW_BIT_DIS] = watchdog_disable_pin;
          next_r.rdata[`PRW_BIT_PIN] = primary_reset_output_in;
          next_r.rdata[`PRW_BIT_CNT +: `PRW_CNT_W] = r.flt_cnt;
          next_r.rdata[`PRW_BIT_STATE +: 5] = r.state;
        end
        `PRW_OFS_IRQ_ST:
          next_r.rdata[`PRW_IRQ_W-1:0] = r.irq_st;
        `PRW_OFS_IRQ_MSK:
          next_r.rdata[`PRW_IRQ_W-1:0] = r.irq_msk;
        default:
          next_r.rdata = '0;
      endcase
    end

    // Open-drain drive follows the next state so the pin comes from a flop
    next_r.rst_val  = `PRW_RST_PIN_VAL;
    next_r.rst_oe_n = !((next_r.state == prw_pkg::PRW_ST_RST_LOW)
                        || (next_r.state == prw_pkg::PRW_ST_LATCHED));

    // Power-on reset, strap sampled while reset is held
    if (rst)
    begin
      next_r            = '0;
      next_r.timer      = TMR_START;
      next_r.ivl        = IVL_MAX;
      next_r.state      = prw_pkg::PRW_ST_STARTUP;
      next_r.pulse_prev = activity_pulse_input;
      next_r.dis_prev   = watchdog_disable_pin;
      next_r.wake_prev  = wake_pin;
      next_r.mask       = `PRW_RST_MASK;
      next_r.latch_en   = !config_strap_pin;
      next_r.strap_dflt = !config_strap_pin;
      next_r.flt_cnt    = `PRW_RST_CNT;
      next_r.irq_st     = `PRW_RST_IRQ;
      next_r.irq_msk    = `PRW_RST_IRQ;
      next_r.rst_oe_n   = `PRW_RST_OE_N;
      next_r.rst_val    = `PRW_RST_PIN_VAL;
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  // State register
  always_ff @(posedge clk)
  begin
    r <= next_r;
  end

  // Outputs straight from the state register
  assign rd_data                   = r.rdata;
  assign irq                       = r.irq;
  assign primary_reset_output_out  = r.rst_val;
  assign primary_reset_output_oe_n = r.rst_oe_n;

endmodule : prw_watchdog

`default_nettype wire

// file: bench/prw_sva.sv
`include "prw_cfg.svh"
`default_nettype none

module prw_sva
#(
  parameter int TICK_CYC     = 2,
  parameter int RUN_TICKS    = 20,
  parameter int RSTLOW_TICKS = 5
)
(
  // Clock, reset and register port
  input wire logic                   clk,
  input wire logic                   rst,
  input wire logic [`PRW_ADDR_W-1:0] addr,
  input wire logic                   wr_en,
  input wire logic                   rd_en,
  input wire logic [`PRW_DATA_W-1:0] wr_data,
  input wire logic [`PRW_DATA_W-1:0] rd_data,
  input wire logic                   irq,
  // Pins
  input wire logic                   watchdog_disable_pin,
  input wire logic                   wake_pin,
  input wire logic                   aux_regulator_three_uv,
  input wire logic                   aux_regulator_four_uv,
  input wire logic                   primary_reset_output_out,
  input wire logic                   primary_reset_output_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // Low phase may run up to one prescale tick longer than RSTLOW_TICKS ticks
  localparam int LO_MIN = RSTLOW_TICKS * TICK_CYC - 1;
  localparam int LO_MAX = (RSTLOW_TICKS + 1) * TICK_CYC;
  localparam int HI_MIN = RUN_TICKS * TICK_CYC;
  int   lo_cnt;
  int   hi_cnt;
  logic mask_q;
  logic msk_q;
  logic clr_q;

  //////////////////////////////////////////////////////////////////////////////
  // Phase lengths and software settings, seen from the ports only
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      lo_cnt <= 0;
      hi_cnt <= 0;
      mask_q <= 1'h0;
      msk_q  <= 1'h0;
      clr_q  <= 1'h0;
    end
    else
    begin
      lo_cnt <= primary_reset_output_oe_n ? 0 : lo_cnt + 1;
      hi_cnt <= primary_reset_output_oe_n ? hi_cnt + 1 : 0;
      if (wr_en && addr == `PRW_OFS_ENABLE)
        mask_q <= wr_data[`PRW_BIT_MASK];
      if (wr_en && addr == `PRW_OFS_IRQ_MSK)
        msk_q <= wr_data[`PRW_IRQ_FAULT];
      // A counter clear ends a latched low phase at no fixed length
      clr_q <= wake_pin || aux_regulator_three_uv || aux_regulator_four_uv
               || (clr_q && !primary_reset_output_oe_n);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_stat_rd;
    rd_en && addr == `PRW_OFS_STATUS;
  endsequence
  sequence s_pull;
    $fell(primary_reset_output_oe_n);
  endsequence
  sequence s_release;
    $rose(primary_reset_output_oe_n) && !clr_q;
  endsequence

  rd_idle_a: assert property (!$past(rd_en) |-> rd_data == '0)
    else $error("read data not idle");
  rd_unmap_a: assert property (rd_en && !(addr inside {`PRW_OFS_ENABLE, `PRW_OFS_FAULT,
    `PRW_OFS_STATUS, `PRW_OFS_IRQ_ST, `PRW_OFS_IRQ_MSK}) |=> rd_data == '0)
    else $error("unmapped read not zero");
  od_out_a: assert property (primary_reset_output_out == 1'h0)
    else $error("reset pin data not low");
  dis_echo_a: assert property (s_stat_rd |=>
    rd_data[`PRW_BIT_DIS] == $past(watchdog_disable_pin)) else $error("disable echo wrong");
  dis_block_a: assert property (s_pull |->
    !($past(watchdog_disable_pin, 2) && $past(watchdog_disable_pin, 3)))
    else $error("reset while disabled");
  low_len_a: assert property (s_release |-> lo_cnt >= LO_MIN && lo_cnt <= LO_MAX)
    else $error("reset low length wrong");
  high_min_a: assert property (s_pull |-> hi_cnt >= HI_MIN)
    else $error("reset came too early");
  mask_hold_a: assert property (s_pull |-> !($past(mask_q) && $past(mask_q, 2)))
    else $error("reset while masked");
  flt_irq_a: assert property (s_pull ##0 msk_q |-> ##[0:2] irq)
    else $error("fault without interrupt");
endmodule : prw_sva

bind prw_watchdog prw_sva #(.TICK_CYC(TICK_CYC), .RUN_TICKS(RUN_TICKS),
  .RSTLOW_TICKS(RSTLOW_TICKS)) i_sva (.clk(clk), .rst(rst), .addr(addr), .wr_en(wr_en),
  .rd_en(rd_en), .wr_data(wr_data), .rd_data(rd_data), .irq(irq),
  .watchdog_disable_pin(watchdog_disable_pin), .wake_pin(wake_pin),
  .aux_regulator_three_uv(aux_regulator_three_uv),
  .aux_regulator_four_uv(aux_regulator_four_uv),
  .primary_reset_output_out(primary_reset_output_out),
  .primary_reset_output_oe_n(primary_reset_output_oe_n));

`default_nettype wire

// file: bench/prw_host.sv
`default_nettype none

module prw_host
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Half period in cycles, zero stops the pulses
  input  wire logic [15:0] half_cyc,
  // Reset line from the watchdog
  input  wire logic        rst_out,
  input  wire logic        rst_oe_n,
  output logic             rst_wire,
  output logic             pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cnt;

  // Pull-up holds the line high unless the watchdog pulls it down
  assign rst_wire = rst_oe_n ? 1'h1 : rst_out;

  // A micro held in reset stops serving; the pin pull-down leaves it low
  always_ff @(posedge clk)
  begin
    if (rst || !rst_wire || half_cyc == 16'h0)
    begin
      cnt   <= 16'h0;
      pulse <= 1'h0;
    end
    else if (cnt >= half_cyc - 16'h1)
    begin
      cnt   <= 16'h0;
      pulse <= ~pulse;
    end
    else
      cnt <= cnt + 16'h1;
  end
endmodule : prw_host

`default_nettype wire

// file: bench/prw_watchdog_test.sv
`include "prw_cfg.svh"
`default_nettype none
`define CHK(g, e) \
  begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
  $display("ERROR %0t: got %h exp %h", $time, g, e); end end

module prw_watchdog_test;
  timeunit 1ns;
  timeprecision 1ps;
  // Shortened timing: one tick is TC cycles
  localparam int TC  = 2;
  localparam int SU  = 40;
  localparam int RL  = 5;
  localparam int PER = TC * (SU + RL);
  logic               clk, rst, wr_en, rd_en, irq;
  logic               dis, strap, wake, uv3, uv4;
  logic               pulse, rst_out, rst_oe_n, rst_wire;
  logic [7:0]         addr;
  prw_pkg::prw_data_t wr_data, rd_data;
  logic [15:0]        half_cyc;
  int                 error_cnt   = 0;
  int                 comparisons = 0;
  int                 falls       = 0;
  int                 cyc         = 0;
  int                 n, c0;

  prw_watchdog
  #(.TICK_CYC(TC), .STARTUP_TICKS(SU), .RUN_TICKS(20), .RSTLOW_TICKS(RL), .OVF_TICKS(4))
  i_dut
  (
    .clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .irq(irq), .activity_pulse_input(pulse),
    .watchdog_disable_pin(dis), .config_strap_pin(strap), .wake_pin(wake),
    .aux_regulator_three_uv(uv3), .aux_regulator_four_uv(uv4),
    .primary_reset_output_in(rst_wire), .primary_reset_output_out(rst_out),
    .primary_reset_output_oe_n(rst_oe_n)
  );
  prw_host i_host
  (
    .clk(clk), .rst(rst), .half_cyc(half_cyc), .rst_out(rst_out),
    .rst_oe_n(rst_oe_n), .rst_wire(rst_wire), .pulse(pulse)
  );

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  // Count reset pulses; a hung run ends at the ceiling
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if ($fell(rst_oe_n))
      falls <= falls + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      complete_run();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input prw_pkg::prw_data_t d);
    @(posedge clk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'h1;
    @(posedge clk);
    wr_en <= 1'h0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input prw_pkg::prw_data_t e);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'h1;
    @(posedge clk);
    rd_en <= 1'h0;
    #1;
    `CHK(rd_data, e)
  endtask : rd

  task automatic idle(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : idle

  task automatic wait_fall(input int lim);
    int m;
    m = falls;
    repeat (lim)
    begin
      @(posedge clk);
      if (falls != m)
        return;
    end
    `CHK(falls, m + 1)
  endtask : wait_fall

  task automatic complete_run();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {rst, strap} = 2'h3;
    {wr_en, rd_en, dis, wake, uv3, uv4} = 6'h0;
    addr     = 8'h0;
    wr_data  = 32'h0;
    half_cyc = 16'h0;
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    // Reset values, unmapped place
    rd(`PRW_OFS_ENABLE, 32'h0);
    rd(`PRW_OFS_FAULT, 32'h0);
    rd(`PRW_OFS_STATUS, 32'h0202);
    rd(8'h14, 32'h0);
    rd(`PRW_OFS_IRQ_MSK, 32'h0);
    $display("test reset values done");
    // Silent host: timeout, pulse, repeat; config reload, interrupt
    wr(`PRW_OFS_IRQ_MSK, 32'h7);
    wr(`PRW_OFS_ENABLE, 32'h0002_0000);
    wait_fall(200);
    c0 = cyc;
    idle(2);
    `CHK(irq, 1'h1)
    wait_fall(200);
    `CHK((cyc - c0) inside {[PER - 2:PER + 8]}, 1'h1)
    rd(`PRW_OFS_ENABLE, 32'h0);
    rd(`PRW_OFS_FAULT, 32'h1);
    rd(`PRW_OFS_FAULT, 32'h0);
    wr(`PRW_OFS_IRQ_MSK, 32'h0);
    idle(2);
    `CHK(irq, 1'h0)
    wr(`PRW_OFS_IRQ_MSK, 32'h7);
    idle(2);
    `CHK(irq, 1'h1)
    wr(`PRW_OFS_IRQ_ST, 32'h7);
    idle(2);
    `CHK(irq, 1'h0)
    $display("test timeout done");
    // Pulses 8 ticks apart keep the watchdog quiet
    @(posedge clk);
    half_cyc <= 16'h8;
    n = falls;
    idle(400);
    `CHK(falls, n)
    rd(`PRW_OFS_STATUS, 32'h0412);
    rd(`PRW_OFS_FAULT, 32'h0);
    // Pulses 2 ticks apart count as none
    @(posedge clk);
    half_cyc <= 16'h2;
    wait_fall(100);
    half_cyc <= 16'h0;
    rd(`PRW_OFS_FAULT, 32'h3);
    rd(`PRW_OFS_IRQ_ST, 32'h3);
    $display("test pulse rate done");
    // Masked faults set the fault flag and interrupt status but pull no reset
    wr(`PRW_OFS_ENABLE, 32'h1);
    n = falls;
    idle(250);
    `CHK(falls, n)
    rd(`PRW_OFS_FAULT, 32'h1);
    // Disable pin; its falling edge starts the start-up timeout
    @(posedge clk);
    dis <= 1'h1;
    wr(`PRW_OFS_ENABLE, 32'h0);
    rd(`PRW_OFS_STATUS, 32'h0113);
    idle(200);
    `CHK(falls, n)
    @(posedge clk);
    dis <= 1'h0;
    wait_fall(100);
    $display("test mask and disable done");
    // Strap low: latch after four faults, each clear source releases
    rst   <= 1'h1;
    strap <= 1'h0;
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    rd(`PRW_OFS_ENABLE, 32'h0002_0000);
    for (int s = 0; s < 3; s++)
    begin
      repeat (4) wait_fall(200);
      idle(300);
      rd(`PRW_OFS_STATUS, 32'h1040);
      rd(`PRW_OFS_IRQ_ST, 32'h5);
      @(posedge clk);
      uv3  <= (s == 0);
      uv4  <= (s == 1);
      wake <= (s == 2);
      idle(2);
      @(posedge clk);
      {uv3, uv4, wake} <= 3'h0;
      idle(2);
      rd(`PRW_OFS_STATUS, 32'h0202);
    end
    $display("test latch done");
    complete_run();
  end
endmodule : prw_watchdog_test

`default_nettype wire
